// *** hdl/cwt_carrier_timer.sv ***
// carrier wave timer: 8-bit reload down counter with two reload registers
// assumes an apb master on clk_i and software that follows the start sequence
// assumes clk_i is an even multiple of the oscillator input so half periods are whole cycles

`timescale 1ns/10ps

// Operation
// - eight-bit down counter with a low-interval and a high-interval reload register
// - load operation writes counter and low-interval reload together
// - reload-again operation copies low-interval reload into the counter
// - high reload operation writes only the high-interval reload register
// - divider mode underflow sets flag, reloads from low-interval, keeps counting
// - divider mode divides the count source by low value plus one
// - carrier mode low phase from low reload, high phase from high reload
// - carrier starts low; each underflow sets flag and alternates reload source
// - without expansion the high phase lasts high value plus one periods
// - with expansion the high phase lasts high value plus one and a half periods
// - carrier low phase lasts low value plus one periods
// - underflow sets the underflow flag, testable by a skip operation
// - the flag clears when its skip is taken, unless an underflow sets it again in that same cycle
// - stopping during a high phase finishes that whole high phase first
// - source bit selects oscillator clock or oscillator clock divided by two
// - run bit one counts; zero stops and holds the count
module cwt_carrier_timer #(
	parameter int CNT_W = cwt_pkg::CNT_W_DEF,
	parameter int XIN_DIV = cwt_pkg::XIN_DIV_DEF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [cwt_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [cwt_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [cwt_pkg::STRB_W-1:0] pstrb_i,
	output logic [cwt_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// carrier and flag
	output logic carrier_output_pin_o,
	output logic second_underflow_flag_o
);

	// refuse geometries the read-back and prescaler cannot serve
	if (CNT_W < 2 || CNT_W > 8) begin : g_bad_cnt_w
		$error("cwt_carrier_timer: CNT_W must be 2 to 8");
	end
	if (XIN_DIV < 2 || (XIN_DIV % 2) != 0) begin : g_bad_xin_div
		$error("cwt_carrier_timer: XIN_DIV must be even and at least 2");
	end
	if (cwt_pkg::CTRL_W != $bits(cwt_pkg::cwt_ctrl_t)) begin : g_bad_ctrl_w
		$error("cwt_carrier_timer: control field width and struct disagree");
	end

	localparam int HW = $clog2(XIN_DIV + 1);

	// apb request bundle
	cwt_pkg::cwt_apb_req_t req;

	// bus state
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [cwt_pkg::DATA_W-1:0] prdata_reg;
	logic [cwt_pkg::DATA_W-1:0] prdata_next;

	// software visible storage
	cwt_pkg::cwt_ctrl_t ctrl_reg;
	cwt_pkg::cwt_ctrl_t ctrl_next;
	logic [CNT_W-1:0] low_interval_reload_reg;
	logic [CNT_W-1:0] low_interval_reload_next;
	logic [CNT_W-1:0] high_interval_reload_reg;
	logic [CNT_W-1:0] high_interval_reload_next;

	// counter core
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	cwt_pkg::cwt_state_t state_reg;
	cwt_pkg::cwt_state_t state_next;
	logic [HW-1:0] ext_reg;
	logic [HW-1:0] ext_next;
	logic carrier_reg;
	logic carrier_next;

	// decode wires
	logic access;
	logic done;
	logic wr_fire;
	logic rd_fire;
	logic lane0;
	logic hit_ctrl;
	logic hit_load;
	logic hit_reload;
	logic hit_high;
	logic hit_count;
	logic hit_skip;
	logic mapped;
	logic [cwt_pkg::DATA_W-1:0] rd_mux;

	// operation strobes
	logic write_control_op;
	logic load_counter_and_low_reload_op;
	logic reload_again_op;
	logic load_high_reload_op;
	logic skip_taken;

	// core wires
	logic tick;
	logic tick_en;
	logic at_zero;
	logic underflow;
	logic flag;
	logic [HW-1:0] half_last;
	logic [cwt_pkg::DATA_W-1:0] count_word;

	// phase decisions
	logic first_access;
	logic phase_end;
	logic ext_end;
	logic [CNT_W-1:0] count_dec;
	cwt_pkg::cwt_state_t resume_state;

	// bundle the request
	assign req.paddr = paddr_i;
	assign req.pwrite = pwrite_i;
	assign req.pwdata = pwdata_i;
	assign req.pstrb = pstrb_i;

	// apb phases: one wait cycle, then completion
	assign access = psel_i & penable_i;
	assign done = access & pready_reg;
	assign wr_fire = done & req.pwrite;
	assign rd_fire = done & ~req.pwrite;
	assign lane0 = req.pstrb[0];

	// address decode
	assign hit_ctrl = (req.paddr == cwt_pkg::OFS_CTRL);
	assign hit_load = (req.paddr == cwt_pkg::OFS_LOAD);
	assign hit_reload = (req.paddr == cwt_pkg::OFS_RELOAD);
	assign hit_high = (req.paddr == cwt_pkg::OFS_HIGH);
	assign hit_count = (req.paddr == cwt_pkg::OFS_COUNT);
	assign hit_skip = (req.paddr == cwt_pkg::OFS_SKIP);
	assign mapped = hit_ctrl | hit_load | hit_reload | hit_high | hit_count | hit_skip;

	// instruction equivalents taken at the completing edge
	assign write_control_op = wr_fire & hit_ctrl & lane0;
	assign load_counter_and_low_reload_op = wr_fire & hit_load & lane0;
	assign reload_again_op = wr_fire & hit_reload;
	assign load_high_reload_op = wr_fire & hit_high & lane0;
	// skip counts as taken only when the returned flag was one
	assign skip_taken = rd_fire & hit_skip & prdata_reg[cwt_pkg::SKIP_FLAG_BIT];

	// counter read-back word: count, both reloads and phase
	assign count_word = {6'h00, state_reg, 8'(high_interval_reload_reg), 8'(low_interval_reload_reg),
		8'(count_reg)};

	// read data selection
	// reload register reads back zero, it is an operation only
	assign rd_mux = hit_ctrl ? 32'(ctrl_reg) :
		hit_load ? 32'(low_interval_reload_reg) :
		hit_high ? 32'(high_interval_reload_reg) :
		hit_count ? count_word :
		hit_skip ? 32'(flag) :
		32'h0000_0000;

	// first access cycle, the one before ready
	assign first_access = access & ~pready_reg;

	// bus answer computed in the first access cycle
	assign pready_next = first_access;
	assign pslverr_next = first_access & ~mapped;
	assign prdata_next = (first_access & ~req.pwrite) ? rd_mux : prdata_reg;

	// control register update
	// upper write data bits are ignored
	assign ctrl_next = write_control_op ? cwt_pkg::cwt_ctrl_t'(req.pwdata[cwt_pkg::CTRL_W-1:0]) : ctrl_reg;

	// reload registers
	assign low_interval_reload_next = load_counter_and_low_reload_op ?
		req.pwdata[CNT_W-1:0] : low_interval_reload_reg;
	assign high_interval_reload_next = load_high_reload_op ?
		req.pwdata[CNT_W-1:0] : high_interval_reload_reg;

	// count source runs only in a counting phase
	assign tick_en = (state_reg == cwt_pkg::ST_LOW) | (state_reg == cwt_pkg::ST_HIGH);
	assign at_zero = (count_reg == '0);
	// half a count source period in clk_i cycles, minus one
	assign half_last = ctrl_reg.source_select_bit ? HW'(XIN_DIV - 1) : HW'(XIN_DIV / 2 - 1);

	// phase boundaries and where a finished high phase goes
	assign phase_end = tick & at_zero;
	assign ext_end = (ext_reg == '0);
	assign count_dec = count_reg - 1'b1;
	assign resume_state = ctrl_reg.run_control_bit ? cwt_pkg::ST_LOW : cwt_pkg::ST_STOP;

	// count source pulses
	cwt_tick_gen #(
		.XIN_DIV(XIN_DIV)
	) u_tick (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.enable_i(tick_en),
		.src_div2_i(ctrl_reg.source_select_bit),
		.tick_o(tick)
	);

	// underflow flag with skip clear
	cwt_flag u_flag (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.set_i(underflow),
		.clr_i(skip_taken),
		.flag_o(flag)
	);

	// phase machine and down counter
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		ext_next = ext_reg;
		underflow = 1'b0;
		case (state_reg)
			cwt_pkg::ST_STOP: begin
				// count and reloads held while stopped
				if (ctrl_reg.run_control_bit) begin
					state_next = cwt_pkg::ST_LOW;
				end
			end
			cwt_pkg::ST_LOW: begin
				// a stop in the underflow cycle wins and drops that underflow
				if (!ctrl_reg.run_control_bit) begin
					state_next = cwt_pkg::ST_STOP;
				end else if (phase_end) begin
					underflow = 1'b1;
					if (ctrl_reg.carrier_generation_enable) begin
						// low phase done, the high phase counts next
						count_next = high_interval_reload_reg;
						state_next = cwt_pkg::ST_HIGH;
					end else begin
						count_next = low_interval_reload_reg;
					end
				end else if (tick) begin
					count_next = count_dec;
				end
			end
			cwt_pkg::ST_HIGH: begin
				// keeps counting after run falls until this high phase ends
				if (phase_end) begin
					underflow = 1'b1;
					count_next = low_interval_reload_reg;
					if (ctrl_reg.carrier_generation_enable && ctrl_reg.high_interval_expansion_enable) begin
						// half a period of high still owed after the last count
						state_next = cwt_pkg::ST_EXT;
						ext_next = half_last;
					end else if (ctrl_reg.run_control_bit) begin
						state_next = cwt_pkg::ST_LOW;
					end else begin
						state_next = cwt_pkg::ST_STOP;
					end
				end else if (tick) begin
					count_next = count_dec;
				end
			end
			cwt_pkg::ST_EXT: begin
				// extra half period of high before the low phase
				if (ext_end) begin
					state_next = resume_state;
				end else begin
					ext_next = ext_reg - 1'b1;
				end
			end
			default: begin
				// unused encodings fall back to stop
				state_next = cwt_pkg::ST_STOP;
			end
		endcase
		// software loads take priority over counting
		if (load_counter_and_low_reload_op) begin
			count_next = req.pwdata[CNT_W-1:0];
		end else if (reload_again_op) begin
			count_next = low_interval_reload_reg;
		end
	end

	// carrier high only in carrier mode during high or expansion
	assign carrier_next = ctrl_next.carrier_generation_enable &
		((state_next == cwt_pkg::ST_HIGH) | (state_next == cwt_pkg::ST_EXT));

	// apb answer registers
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// software visible registers
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl_reg <= cwt_pkg::cwt_ctrl_t'(cwt_pkg::CTRL_RESET);
			low_interval_reload_reg <= CNT_W'(cwt_pkg::CNT_RESET);
			high_interval_reload_reg <= CNT_W'(cwt_pkg::CNT_RESET);
		end else begin
			ctrl_reg <= ctrl_next;
			low_interval_reload_reg <= low_interval_reload_next;
			high_interval_reload_reg <= high_interval_reload_next;
		end
	end

	// counter core registers
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_reg <= cwt_pkg::ST_STOP;
			count_reg <= CNT_W'(cwt_pkg::CNT_RESET);
			ext_reg <= '0;
			carrier_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			ext_reg <= ext_next;
			carrier_reg <= carrier_next;
		end
	end

	// outputs straight from flops
	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign carrier_output_pin_o = carrier_reg;
	assign second_underflow_flag_o = flag;

endmodule

// *** hdl/cwt_pkg.sv ***
// constants, types and register map of the carrier wave timer
// assumes a single clock domain and an apb slave port of 32 data bits

package cwt_pkg;

	// apb geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOAD = 8'h04;
	localparam logic [7:0] OFS_RELOAD = 8'h08;
	localparam logic [7:0] OFS_HIGH = 8'h0c;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] OFS_SKIP = 8'h14;

	// control register fields (carrier_timer_control)
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_SRC_BIT = 1;
	localparam int CTRL_CARRIER_OUTPUT_PIN_BIT = 2;
	localparam int CTRL_EXP_BIT = 3;
	localparam int CTRL_W = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// count read-back field positions
	localparam int RD_CNT_LSB = 0;
	localparam int RD_LOW_LSB = 8;
	localparam int RD_HIGH_LSB = 16;
	localparam int RD_STATE_LSB = 24;

	// skip register field
	localparam int SKIP_FLAG_BIT = 0;

	// counter defaults and reset values
	localparam int CNT_W_DEF = 8;
	localparam logic [7:0] CNT_RESET = 8'h00;

	// clocks of clk_i per period of the oscillator input
	localparam int XIN_DIV_DEF = 2;

	// phase of the counter, gray coded along stop, low, high, expansion
	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_LOW = 2'b01,
		ST_HIGH = 2'b11,
		ST_EXT = 2'b10
	} cwt_state_t;

	// control bits as written by write_control_op
	typedef struct packed {
		logic high_interval_expansion_enable;
		logic carrier_generation_enable;
		logic source_select_bit;
		logic run_control_bit;
	} cwt_ctrl_t;

	// one apb request as seen by the slave
	typedef struct packed {
		logic [7:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} cwt_apb_req_t;

endpackage

// *** hdl/cwt_tick_gen.sv ***
// count source pulse generator of the carrier wave timer
// assumes clk_i runs at XIN_DIV times the oscillator input rate

`timescale 1ns/10ps

module cwt_tick_gen #(
	parameter int XIN_DIV = cwt_pkg::XIN_DIV_DEF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// control
	input wire logic enable_i,
	input wire logic src_div2_i,
	// count pulse
	output logic tick_o
);

	localparam int CW = $clog2(2 * XIN_DIV + 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic [CW-1:0] last;

	// period is one oscillator cycle or two of them
	assign last = src_div2_i ? CW'(2 * XIN_DIV - 1) : CW'(XIN_DIV - 1);
	assign tick_o = enable_i & (cnt_reg == last);
	// held at zero while idle so the first pulse comes one full period after start
	assign cnt_next = (!enable_i || tick_o) ? '0 : cnt_reg + 1'b1;

	// prescaler counter
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule

// *** hdl/cwt_flag.sv ***
// sticky event flag, set by hardware and cleared by a taken skip
// assumes set and clear are one-cycle pulses in the clk_i domain

`timescale 1ns/10ps

module cwt_flag (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// events
	input wire logic set_i,
	input wire logic clr_i,
	// state
	output logic flag_o
);

	logic flag_reg;
	logic flag_next;

	// a set in the clearing cycle survives
	assign flag_next = set_i | (flag_reg & ~clr_i);
	assign flag_o = flag_reg;

	// flag storage
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

endmodule

// *** test/cwt_properties.sv ***
// port assertions for the carrier wave timer
// assumes clk_i with a synchronous active-low resetn_i
`timescale 1ns/10ps
module cwt_properties (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [cwt_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [cwt_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [cwt_pkg::STRB_W-1:0] pstrb_i,
	input wire logic [cwt_pkg::DATA_W-1:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// timer outputs
	input wire logic carrier_output_pin_o,
	input wire logic second_underflow_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// completed transfer, completed skip read, decoded address
	wire done = psel_i && penable_i && pready_o;
	wire skip_rd = done && !pwrite_i && paddr_i == cwt_pkg::OFS_SKIP;
	wire mapped = paddr_i[1:0] == 2'h0 && paddr_i <= cwt_pkg::OFS_SKIP;
	// first access cycle, then one wait and a single ready pulse
	sequence s_access;
		psel_i && $rose(penable_i);
	endsequence
	sequence s_one_wait;
		!pready_o ##1 pready_o ##1 !pready_o;
	endsequence
	a_ready_wait: assert property (s_access |-> s_one_wait)
		else $error("ready not after one wait state");
	a_ready_qual: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside an access");
	a_err_unmapped: assert property (pslverr_o |-> pready_o && !mapped)
		else $error("error on a mapped address");
	a_err_rdzero: assert property (pslverr_o && !pwrite_i |-> prdata_o == '0)
		else $error("refused read returns data");
	a_mapped_ok: assert property (done && mapped |-> !pslverr_o)
		else $error("mapped access refused");
	a_skip_value: assert property (skip_rd |-> prdata_o == {31'h0, $past(second_underflow_flag_o)})
		else $error("skip read does not return flag");
	a_flag_clear: assert property ($fell(second_underflow_flag_o) |-> $past(skip_rd))
		else $error("flag cleared without skip");
	a_rise_flag: assert property ($rose(carrier_output_pin_o) |-> second_underflow_flag_o)
		else $error("carrier rose without underflow");
	a_high_min: assert property ($rose(carrier_output_pin_o) |=> carrier_output_pin_o)
		else $error("high phase shorter than a period");
	a_low_min: assert property ($fell(carrier_output_pin_o) |=> !carrier_output_pin_o)
		else $error("low phase shorter than a period");
endmodule
bind cwt_carrier_timer cwt_properties i_props (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .carrier_output_pin_o, .second_underflow_flag_o);

// *** test/cwt_pin_model.sv ***
// monitor standing for the load on the carrier pin
// assumes the pin changes only at rising edges of clk_i
`timescale 1ns/10ps
module cwt_pin_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// carrier pin
	input wire logic pin_i,
	// last finished phase lengths in clk cycles
	output int hi_len_o,
	output int lo_len_o
);
	int n;
	logic last;
	// time each level, keep the length of the phase just ended
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			n <= 0;
			last <= 1'h0;
			hi_len_o <= 0;
			lo_len_o <= 0;
		end else if (pin_i !== last) begin
			if (last)
				hi_len_o <= n;
			else
				lo_len_o <= n;
			n <= 1;
			last <= pin_i;
		end else
			n <= n + 1;
	end
endmodule

// *** test/test_cwt_carrier_timer.sv ***
// self-checking bench for the carrier wave timer
// assumes design, checker and pin monitor compiled first
`timescale 1ns/10ps
module test_cwt_carrier_timer;
	logic clk_i;
	logic resetn_i;
	logic psel_i;
	logic penable_i;
	logic pwrite_i;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [3:0] pstrb_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic carrier_output_pin_o;
	logic second_underflow_flag_o;
	int hi_len;
	int lo_len;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic er;
	cwt_carrier_timer i_dut (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.pstrb_i, .prdata_o, .pready_o, .pslverr_o, .carrier_output_pin_o, .second_underflow_flag_o);
	cwt_pin_model i_pin (.clk_i, .resetn_i, .pin_i(carrier_output_pin_o), .hi_len_o(hi_len), .lo_len_o(lo_len));
	// 20 MHz clock and cycle count
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc <= cyc + 1;
	task end_of_test;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// a run-out wait ends the test
	task hang(input int k);
		if (k >= 200) begin
			n_errors++;
			end_of_test();
		end
	endtask
	// one apb transfer, result in rd and er
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready_o !== 1'h1 && k < 200);
		hang(k);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask
	// wait until the flag (s=0) or the pin (s=1) shows v
	task wsig(input logic s, input logic v);
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while ((s ? carrier_output_pin_o : second_underflow_flag_o) !== v && k < 200);
		hang(k);
	endtask
	// reset values, writes, read-back, unmapped address
	task t_regs;
		apb(1'h0, cwt_pkg::OFS_COUNT, 32'h0);
		chk("count reset", rd, 32'h0);
		chk("pin reset", {31'h0, carrier_output_pin_o}, 32'h0);
		apb(1'h1, cwt_pkg::OFS_LOAD, 32'h5a);
		apb(1'h1, cwt_pkg::OFS_HIGH, 32'h33);
		apb(1'h0, cwt_pkg::OFS_COUNT, 32'h0);
		chk("load and high", rd, 32'h00335a5a);
		apb(1'h1, cwt_pkg::OFS_CTRL, 32'he);
		apb(1'h0, cwt_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", rd, 32'he);
		pstrb_i <= 4'he;
		apb(1'h1, cwt_pkg::OFS_CTRL, 32'h0);
		pstrb_i <= 4'hf;
		apb(1'h0, cwt_pkg::OFS_CTRL, 32'h0);
		chk("ctrl lane0 off", rd, 32'he);
		apb(1'h0, 8'h40, 32'h0);
		chk("unmapped", {rd[30:0], er}, 32'h1);
	endtask
	// divider period, skip clear, hold and reload-again
	task t_div(input logic s);
		int t0;
		logic [31:0] c;
		apb(1'h0, cwt_pkg::OFS_SKIP, 32'h0);
		apb(1'h1, cwt_pkg::OFS_LOAD, 32'h3);
		apb(1'h1, cwt_pkg::OFS_CTRL, {30'h0, s, 1'h1});
		wsig(1'h0, 1'h1);
		t0 = cyc;
		apb(1'h0, cwt_pkg::OFS_SKIP, 32'h0);
		chk("skip taken", rd, 32'h1);
		@(posedge clk_i);
		chk("flag clear", {31'h0, second_underflow_flag_o}, 32'h0);
		wsig(1'h0, 1'h1);
		chk("div period", cyc - t0, s ? 32'h10 : 32'h8);
		chk("pin idle", {31'h0, carrier_output_pin_o}, 32'h0);
		apb(1'h1, cwt_pkg::OFS_CTRL, {30'h0, s, 1'h0});
		apb(1'h0, cwt_pkg::OFS_COUNT, 32'h0);
		c = rd;
		apb(1'h0, cwt_pkg::OFS_COUNT, 32'h0);
		chk("count held", rd, c);
		apb(1'h1, cwt_pkg::OFS_RELOAD, 32'h0);
		apb(1'h0, cwt_pkg::OFS_COUNT, 32'h0);
		chk("reload again", {24'h0, rd[7:0]}, 32'h3);
	endtask
	// carrier phases, stop inside a high phase
	task t_car(input logic x);
		apb(1'h1, cwt_pkg::OFS_LOAD, 32'h2);
		apb(1'h1, cwt_pkg::OFS_HIGH, 32'h3);
		apb(1'h1, cwt_pkg::OFS_CTRL, {28'h0, x, 3'h5});
		wsig(1'h1, 1'h1);
		wsig(1'h1, 1'h0);
		wsig(1'h1, 1'h1);
		apb(1'h1, cwt_pkg::OFS_CTRL, {28'h0, x, 3'h4});
		wsig(1'h1, 1'h0);
		@(posedge clk_i);
		chk("high len", hi_len, x ? 32'h9 : 32'h8);
		chk("low len", lo_len, 32'h6);
		apb(1'h0, cwt_pkg::OFS_COUNT, 32'h0);
		chk("stopped", rd, 32'h00030202);
		chk("pin low", {31'h0, carrier_output_pin_o}, 32'h0);
	endtask
	initial begin
		resetn_i = 1'h0;
		psel_i = 1'h0;
		penable_i = 1'h0;
		pwrite_i = 1'h0;
		paddr_i = 8'h0;
		pwdata_i = 32'h0;
		pstrb_i = 4'hf;
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'h1;
		t_regs();
		t_div(1'h0);
		t_div(1'h1);
		t_car(1'h0);
		t_car(1'h1);
		end_of_test();
	end
endmodule
